// ### four_level_chk.sv
`include "intr_regs.vh"
// ****************************************
// Checker on the unit's own ports
// ****************************************
module four_level_chk #(
  parameter ED = 1
) (
  input wire             clk,             // Core clock
  input wire             nrst,            // Async reset, active low
  input wire             sync_program,    // Program exception
  input wire             sync_debug,      // Synchronous debug event
  input wire             sync_err_report, // Error report
  input wire             async_nmi,       // Non-maskable level
  input wire             ret_valid,       // Return pulse
  input wire [2:0]       ret_level,       // Return pair
  input wire             reg_re,          // Read strobe
  input wire [31:0]      reg_rdata_q,     // Read data
  input wire             redirect_q,      // Redirect pulse
  input wire             take_q,          // Take pulse
  input wire [2:0]       take_pair_q,     // Pair of take
  input wire [`MS_W-1:0] ms_q             // Machine state
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // Enable bits each level clears on entry
  function automatic [3:0] low_mask(input [2:0] p);
    case (p)
      `LVL_CRIT: low_mask = 4'h3;
      `LVL_DBG:  low_mask = 4'h7;
      `LVL_MC:   low_mask = 4'hF;
      default:   low_mask = 4'h1;
    endcase
  endfunction

  // Standard takes land in pair 0 or, for guests, pair 4
  sequence std_take;
    take_q && (take_pair_q == `LVL_STD || take_pair_q == `LVL_GUEST);
  endsequence
  sequence ret_req;
    ret_valid && ret_level < 3'h5;
  endsequence

  take_redir_a: assert property (take_q |-> redirect_q)
    else $error("take without redirect");
  std_gate_a: assert property (std_take |-> $past(sync_program) || $past(ms_q[0]))
    else $error("standard take while gated");
  crit_gate_a: assert property (take_q && take_pair_q == `LVL_CRIT && ED == 1 |-> $past(ms_q[1]))
    else $error("critical take while gated");
  dbg_gate_a: assert property (take_q && take_pair_q == `LVL_DBG |-> $past(ms_q[2]))
    else $error("debug take while gated");
  mc_gate_a: assert property (take_q && take_pair_q == `LVL_MC |->
    $past(async_nmi) || $past(sync_err_report) || $past(ms_q[3]))
    else $error("machine check take while gated");
  entry_mask_a: assert property (take_q |-> (ms_q[3:0] & low_mask(take_pair_q)) == 4'h0)
    else $error("lower enables left set on entry");
  guest_pair_a: assert property (std_take |-> (take_pair_q == `LVL_GUEST) == $past(ms_q[4]))
    else $error("standard take in wrong pair");
  guest_keep_a: assert property (take_q |-> ms_q[4] == $past(ms_q[4]))
    else $error("guest bit changed by take");
  nmi_take_a: assert property (async_nmi && !ret_valid |=> take_q && take_pair_q == `LVL_MC)
    else $error("nmi not taken at once");
  sync_live_a: assert property (sync_program && !sync_debug && !async_nmi && !sync_err_report
    && !ret_valid && ms_q[3:0] == 4'h0 |=> std_take)
    else $error("program exception masked");
  ret_wins_a: assert property (ret_req |=> redirect_q && !take_q)
    else $error("return not redirected");
  rd_idle_a: assert property (!reg_re |=> reg_rdata_q == 32'h00000000)
    else $error("read data outside read slot");
endmodule // four_level_chk

bind four_level_interrupt_unit four_level_chk #(.ED(ENHANCED_DEBUG)) u_chk (
  .clk(clk), .nrst(nrst), .sync_program(sync_program), .sync_debug(sync_debug),
  .sync_err_report(sync_err_report),
  .async_nmi(async_nmi), .ret_valid(ret_valid), .ret_level(ret_level), .reg_re(reg_re),
  .reg_rdata_q(reg_rdata_q), .redirect_q(redirect_q), .take_q(take_q),
  .take_pair_q(take_pair_q), .ms_q(ms_q));

// ### four_level_interrupt_unit.v
// Functional notes
// - Take only the top pending condition that is enabled or needs no enable.
// - On take save address and state, jump to vector, update machine state.
// - Four levels, each saving into its own save pair.
// - Taking a level disables asynchronous interrupts of all lower levels.
// - Synchronous exceptions stay active whatever the level masking, except sync debug, gated by debug enable with enhanced debug.
// - Standard level: program, external, timer, doorbell; async gated by external enable.
// - Critical level: critical input, watchdog, critical doorbell; gated by critical enable.
// - Without enhanced debug, debug exceptions go through the critical level.
// - With enhanced debug, debug level with own pair, gated by debug enable.
// - Machine check: error reports, async machine check, nmi; async check gated.
// - Guest state uses a separate guest pair for standard interrupts.
// - Cause bits recorded in a syndrome register for the handler.
// - Return for a level resumes at saved address and restores saved state.
`include "intr_regs.vh"
module four_level_interrupt_unit #(
  parameter AW             = 32,
  parameter ENHANCED_DEBUG = 1
) (
  input  wire          clk,             // Core clock, 200 MHz
  input  wire          nrst,            // Async reset, active low
  input  wire [AW-1:0] cur_addr,        // Address of instruction to be interrupted
  input  wire          sync_program,    // Program exception pulse
  input  wire          sync_debug,      // Synchronous debug event pulse
  input  wire          sync_err_report, // Error report pulse
  input  wire          async_ext_in,    // External input level
  input  wire          async_timer,     // Timer exception level
  input  wire          async_doorbell,  // Doorbell level
  input  wire          async_crit_in,   // Critical input level
  input  wire          async_watchdog,  // Watchdog level
  input  wire          async_crit_db,   // Critical doorbell level
  input  wire          async_debug,     // Asynchronous debug level
  input  wire          async_mcheck,    // Asynchronous machine check level
  input  wire          async_nmi,       // Non-maskable interrupt level
  input  wire          ret_valid,       // Return from interrupt pulse
  input  wire [2:0]    ret_level,       // Pair to return from
  input  wire [7:0]    reg_addr,        // Register byte address
  input  wire [31:0]   reg_wdata,       // Register write data
  input  wire          reg_we,          // Write strobe
  input  wire          reg_re,          // Read strobe
  output reg  [31:0]   reg_rdata_q,     // Read data, cycle after strobe
  output reg           redirect_q,      // Fetch redirect pulse
  output reg  [AW-1:0] redirect_addr_q, // Redirect target
  output reg           take_q,          // Interrupt taken pulse
  output reg  [2:0]    take_pair_q,     // Pair used by that take
  output reg  [`MS_W-1:0] ms_q,         // Machine state register
  output reg           irq_q            // Level interrupt out
);
  // ****************************************
  // Declarations
  // ****************************************
  reg  [AW-1:0]          vec_base_q;
  reg  [`NUM_CAUSES-1:0] syndrome_q;
  reg  [4:0]             irq_status_q;
  reg  [4:0]             irq_mask_q;
  reg  [3:0]             last_cause_q;
  reg  [2:0]             last_pair_q;
  reg  [`NUM_CAUSES-1:0] pend;
  reg  [`NUM_CAUSES-1:0] elig;
  reg  [2:0]             lvl;
  reg  [2:0]             pair;
  reg  [`MS_W-1:0]       ms_d;
  reg  [31:0]            rd_d;
  reg  [4:0]             status_d;
  wire                   any;
  wire [3:0]             idx;
  wire                   take;
  wire                   ret;
  wire [AW-1:0]          pair_addr  [0:`NUM_PAIRS-1];
  wire [`MS_W-1:0]       pair_state [0:`NUM_PAIRS-1];
  wire                   save_hit;
  wire [2:0]             save_idx;
  wire [2:0]             ret_pair;
  wire [`NUM_CAUSES-1:0] cause_hot;
  wire [3:0]             ext_en;
  wire [AW-1:0]          vec_addr;
  wire                   ed;
  assign ed = (ENHANCED_DEBUG != 0);

  // ****************************************
  // Pending and eligible conditions
  // ****************************************
  // Bit order of pend is the priority order
  always @* begin
    pend                    = {`NUM_CAUSES{1'b0}};
    pend[`CA_NMI]           = async_nmi;
    pend[`CA_MC_ASYNC]      = async_mcheck;
    pend[`CA_ERR_REPORT]    = sync_err_report;
    pend[`CA_DBG_SYNC]      = sync_debug;
    pend[`CA_DBG_ASYNC]     = async_debug;
    pend[`CA_CRIT_IN]       = async_crit_in;
    pend[`CA_WATCHDOG]      = async_watchdog;
    pend[`CA_CRIT_DOORBELL] = async_crit_db;
    pend[`CA_PROGRAM]       = sync_program;
    pend[`CA_EXT_IN]        = async_ext_in;
    pend[`CA_TIMER]         = async_timer;
    pend[`CA_DOORBELL]      = async_doorbell;
  end

  // Enables per condition; program and error report need none, sync debug needs debug enable with enhanced debug
  always @* begin
    elig                    = pend;
    elig[`CA_NMI]           = pend[`CA_NMI];
    elig[`CA_MC_ASYNC]      = pend[`CA_MC_ASYNC] & ms_q[`MS_MC_EN];
    elig[`CA_ERR_REPORT]    = pend[`CA_ERR_REPORT];
    elig[`CA_DBG_SYNC]      = pend[`CA_DBG_SYNC] & (~ed | ms_q[`MS_DBG_EN]);
    elig[`CA_DBG_ASYNC]     = pend[`CA_DBG_ASYNC] &
                              (ed ? ms_q[`MS_DBG_EN] : ms_q[`MS_CRIT_EN]);
    elig[`CA_CRIT_IN]       = pend[`CA_CRIT_IN] & ms_q[`MS_CRIT_EN];
    elig[`CA_WATCHDOG]      = pend[`CA_WATCHDOG] & ms_q[`MS_CRIT_EN];
    elig[`CA_CRIT_DOORBELL] = pend[`CA_CRIT_DOORBELL] & ms_q[`MS_CRIT_EN];
    elig[`CA_PROGRAM]       = pend[`CA_PROGRAM];
    elig[`CA_EXT_IN]        = pend[`CA_EXT_IN] & ms_q[`MS_EXT_EN];
    elig[`CA_TIMER]         = pend[`CA_TIMER] & ms_q[`MS_EXT_EN];
    elig[`CA_DOORBELL]      = pend[`CA_DOORBELL] & ms_q[`MS_EXT_EN];
  end

  // Winner of the fixed order
  prio_pick #(
    .N  (`NUM_CAUSES),
    .IW (4)
  ) u_pick (
    .req (elig),
    .any (any),
    .idx (idx)
  );

  // A return owns its cycle; a condition still pending and enabled next cycle is taken then, a sync pulse is lost
  assign ret  = ret_valid & (ret_level < `NUM_PAIRS);
  assign take = any & ~ret;

  // ****************************************
  // Level and pair of the winner
  // ****************************************
  always @* begin
    case (idx)
      `CA_NMI, `CA_MC_ASYNC, `CA_ERR_REPORT: lvl = `LVL_MC;
      `CA_DBG_SYNC, `CA_DBG_ASYNC: lvl = ed ? `LVL_DBG : `LVL_CRIT;
      `CA_CRIT_IN, `CA_WATCHDOG, `CA_CRIT_DOORBELL: lvl = `LVL_CRIT;
      default: lvl = `LVL_STD;
    endcase
  end

  // Guest state diverts standard saves to the guest pair
  always @* begin
    if (lvl == `LVL_STD && ms_q[`MS_GUEST])
      pair = `LVL_GUEST;
    else
      pair = lvl;
  end

  // Lower-level enables cleared on entry, the level's own enable cleared too
  assign ext_en = (lvl == `LVL_MC)   ? 4'hF :
                  (lvl == `LVL_DBG)  ? 4'h7 :
                  (lvl == `LVL_CRIT) ? 4'h3 : 4'h1;
  assign ret_pair = ret_level;
  assign vec_addr = vec_base_q | ({{(AW-4){1'b0}}, idx} << `VEC_SHIFT);

  // ****************************************
  // Save/restore pairs
  // ****************************************
  assign save_hit = reg_we && (reg_addr >= `OFS_SAVE_BASE) &&
                    (reg_addr < (`OFS_SAVE_BASE + 8'h28)) && (reg_addr[1:0] == 2'b00);
  assign save_idx = reg_addr[5:3] - 3'h4;

  genvar g;
  generate
    for (g = 0; g < `NUM_PAIRS; g = g + 1) begin : g_pair
      save_pair #(
        .AW (AW),
        .SW (`MS_W)
      ) u_pair (
        .clk       (clk),
        .nrst      (nrst),
        .capture   (take && (pair == g)),
        .cap_addr  (cur_addr),
        .cap_state (ms_q),
        .wr_addr   (save_hit && (save_idx == g) && !reg_addr[2]),
        .wr_state  (save_hit && (save_idx == g) && reg_addr[2]),
        .wdata     (reg_wdata[AW-1:0]),
        .addr_q    (pair_addr[g]),
        .state_q   (pair_state[g])
      );
    end
  endgenerate

  // ****************************************
  // Machine state next value
  // ****************************************
  // Hardware update wins over a software write in the same cycle
  always @* begin
    ms_d = ms_q;
    if (reg_we && reg_addr == `OFS_MACHINE_STATE)
      ms_d = reg_wdata[`MS_W-1:0];
    if (ret)
      ms_d = pair_state[ret_pair];
    else if (take)
      ms_d = ms_q & ~{1'b0, ext_en};
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ms_q <= `MS_RESET;
    end else begin
      ms_q <= ms_d;
    end
  end

  // ****************************************
  // Redirect to vector or saved address
  // ****************************************
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      redirect_q      <= 1'b0;
      redirect_addr_q <= {AW{1'b0}};
      take_q          <= 1'b0;
      take_pair_q     <= 3'h0;
    end else begin
      redirect_q <= take | ret;
      take_q     <= take;
      if (ret)
        redirect_addr_q <= pair_addr[ret_pair];
      else if (take)
        redirect_addr_q <= vec_addr;
      if (take)
        take_pair_q <= pair;
    end
  end

  // ****************************************
  // Syndrome and take record
  // ****************************************
  assign cause_hot = {{(`NUM_CAUSES-1){1'b0}}, 1'b1} << idx;

  // Replaced on every take, so until a write-one-to-clear it names the latest cause
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      syndrome_q   <= {`NUM_CAUSES{1'b0}};
      last_cause_q <= 4'h0;
      last_pair_q  <= 3'h0;
    end else if (take) begin
      syndrome_q   <= cause_hot;
      last_cause_q <= idx;
      last_pair_q  <= pair;
    end else if (reg_we && reg_addr == `OFS_SYNDROME) begin
      syndrome_q <= syndrome_q & ~reg_wdata[`NUM_CAUSES-1:0];
    end
  end

  // ****************************************
  // Event status, mask and interrupt out
  // ****************************************
  // One sticky bit per pair taken; set beats write-one-to-clear
  always @* begin
    status_d = irq_status_q;
    if (reg_we && reg_addr == `OFS_IRQ_STATUS)
      status_d = status_d & ~reg_wdata[4:0];
    if (take)
      status_d = status_d | (5'h01 << pair);
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_status_q <= 5'h00;
      irq_mask_q   <= 5'h00;
      vec_base_q   <= `VECTOR_BASE_RESET;
      irq_q        <= 1'b0;
    end else begin
      irq_status_q <= status_d;
      irq_q        <= |(status_d & irq_mask_q);
      if (reg_we && reg_addr == `OFS_IRQ_MASK)
        irq_mask_q <= reg_wdata[4:0];
      if (reg_we && reg_addr == `OFS_VECTOR_BASE)
        vec_base_q <= reg_wdata[AW-1:0];
    end
  end

  // ****************************************
  // Register read port
  // ****************************************
  // Unmapped addresses read as zero
  always @* begin
    rd_d = 32'h00000000;
    case (reg_addr)
      `OFS_MACHINE_STATE: rd_d[`MS_W-1:0] = ms_q;
      `OFS_VECTOR_BASE:   rd_d[AW-1:0] = vec_base_q;
      `OFS_SYNDROME:      rd_d[`NUM_CAUSES-1:0] = syndrome_q;
      `OFS_IRQ_STATUS:    rd_d[4:0] = irq_status_q;
      `OFS_IRQ_MASK:      rd_d[4:0] = irq_mask_q;
      `OFS_LAST_TAKE:     rd_d[6:0] = {last_pair_q, last_cause_q};
      default: begin
        if ((reg_addr >= `OFS_SAVE_BASE) && (reg_addr < (`OFS_SAVE_BASE + 8'h28)) &&
            (reg_addr[1:0] == 2'b00)) begin
          if (reg_addr[2])
            rd_d[`MS_W-1:0] = pair_state[save_idx];
          else
            rd_d[AW-1:0] = pair_addr[save_idx];
        end
      end
    endcase
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata_q <= 32'h00000000;
    end else if (reg_re) begin
      reg_rdata_q <= rd_d;
    end else begin
      reg_rdata_q <= 32'h00000000;
    end
  end
endmodule // four_level_interrupt_unit

// ### intr_regs.vh
`ifndef INTR_REGS_VH
`define INTR_REGS_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define OFS_MACHINE_STATE   8'h00
`define OFS_VECTOR_BASE     8'h04
`define OFS_SYNDROME        8'h08
`define OFS_IRQ_STATUS      8'h0C
`define OFS_IRQ_MASK        8'h10
`define OFS_LAST_TAKE       8'h14
`define OFS_SAVE_BASE       8'h20
// ****************************************
// Machine state bit positions
// ****************************************
`define MS_EXT_EN           0
`define MS_CRIT_EN          1
`define MS_DBG_EN           2
`define MS_MC_EN            3
`define MS_GUEST            4
`define MS_W                5
`define MS_RESET            5'h00
// ****************************************
// Interrupt levels and save pair numbers
// ****************************************
`define LVL_STD             3'h0
`define LVL_CRIT            3'h1
`define LVL_DBG             3'h2
`define LVL_MC              3'h3
`define LVL_GUEST           3'h4
`define NUM_PAIRS           5
// ****************************************
// Cause indices, highest priority first
// ****************************************
`define CA_NMI              4'h0
`define CA_MC_ASYNC         4'h1
`define CA_ERR_REPORT       4'h2
`define CA_DBG_SYNC         4'h3
`define CA_DBG_ASYNC        4'h4
`define CA_CRIT_IN          4'h5
`define CA_WATCHDOG         4'h6
`define CA_CRIT_DOORBELL    4'h7
`define CA_PROGRAM          4'h8
`define CA_EXT_IN           4'h9
`define CA_TIMER            4'hA
`define CA_DOORBELL         4'hB
`define NUM_CAUSES          12
// ****************************************
// Vector spacing and reset values
// ****************************************
`define VEC_SHIFT           4
`define VECTOR_BASE_RESET   32'h00000000
`endif

// ### pipe_model.sv
`include "intr_regs.vh"
// ****************************************
// Pipeline and interrupt sources
// ****************************************
module pipe_model (
  input  wire        clk,             // Core clock
  input  wire        nrst,            // Async reset, active low
  input  wire        fire,            // Raise conditions
  input  wire [11:0] fire_mask,       // Conditions by cause index
  input  wire [31:0] fire_addr,       // Address now executing
  input  wire        take_q,          // Take seen
  input  wire        redirect_q,      // Redirect seen
  input  wire [31:0] redirect_addr_q, // Redirect target
  output reg  [11:0] cond_q,          // Condition lines
  output reg  [31:0] cur_addr_q       // Address offered
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam [11:0] sync_bits = (12'h001 << `CA_ERR_REPORT) | (12'h001 << `CA_DBG_SYNC)
                              | (12'h001 << `CA_PROGRAM);

  // Sync events last one cycle; all levels drop the cycle after any take, so nmi may be taken twice
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cond_q <= 12'h000;
      cur_addr_q <= 32'h00000000;
    end else if (fire) begin
      cond_q <= fire_mask;
      cur_addr_q <= fire_addr;
    end else begin
      cond_q <= take_q ? 12'h000 : (cond_q & ~sync_bits);
      if (redirect_q) begin
        cur_addr_q <= redirect_addr_q; // Fetch follows redirect
      end
    end
  end
endmodule // pipe_model

// ### prio_pick.v
// ****************************************
// Fixed priority picker, bit 0 wins
// ****************************************
module prio_pick #(
  parameter N  = 12,
  parameter IW = 4
) (
  input  wire [N-1:0]  req,        // Eligible conditions
  output reg           any,        // At least one eligible
  output reg  [IW-1:0] idx         // Index of the winner
);
  integer i;
  // Scan downward so the lowest index is left standing
  always @* begin
    any = 1'b0;
    idx = {IW{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        any = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end
endmodule // prio_pick

// ### save_pair.v
// ****************************************
// One save/restore pair: address and state
// ****************************************
module save_pair #(
  parameter AW = 32,
  parameter SW = 5
) (
  input  wire          clk,        // Core clock
  input  wire          nrst,       // Async reset, active low
  input  wire          capture,    // Take into this pair
  input  wire [AW-1:0] cap_addr,   // Interrupted address
  input  wire [SW-1:0] cap_state,  // Machine state before take
  input  wire          wr_addr,    // Software write of address word
  input  wire          wr_state,   // Software write of state word
  input  wire [AW-1:0] wdata,      // Software write data
  output reg  [AW-1:0] addr_q,     // Saved address
  output reg  [SW-1:0] state_q     // Saved machine state
);
  // Capture by hardware outranks a software write in the same cycle
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      addr_q  <= {AW{1'b0}};
      state_q <= {SW{1'b0}};
    end else if (capture) begin
      addr_q  <= cap_addr;
      state_q <= cap_state;
    end else begin
      if (wr_addr)
        addr_q <= wdata;
      if (wr_state)
        state_q <= wdata[SW-1:0];
    end
  end
endmodule // save_pair

// ### tb_top.sv
`include "intr_regs.vh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
// ****************************************
// Bench top
// ****************************************
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] base = 32'h10000000;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic        reg_we = 1'b0;
  logic        reg_re = 1'b0;
  logic        ret_valid = 1'b0;
  logic [2:0]  ret_level = 3'h0;
  logic        fire = 1'b0;
  logic [11:0] fire_mask = 12'h000;
  logic [31:0] fire_addr = 32'h00000000;
  logic [11:0] cond;
  logic [31:0] cur_addr, reg_rdata_q, redirect_addr_q;
  logic        redirect_q, take_q, irq_q, take_b;
  logic [2:0]  take_pair_q, pair_b;
  logic [4:0]  ms_q, ms_b;
  int          n_fail = 0;
  int          num_checks = 0;
  int          cyc = 0;

  four_level_interrupt_unit u_dut (
    .clk(clk), .nrst(nrst), .cur_addr(cur_addr), .sync_program(cond[`CA_PROGRAM]),
    .sync_debug(cond[`CA_DBG_SYNC]), .sync_err_report(cond[`CA_ERR_REPORT]),
    .async_ext_in(cond[`CA_EXT_IN]), .async_timer(cond[`CA_TIMER]),
    .async_doorbell(cond[`CA_DOORBELL]), .async_crit_in(cond[`CA_CRIT_IN]),
    .async_watchdog(cond[`CA_WATCHDOG]), .async_crit_db(cond[`CA_CRIT_DOORBELL]),
    .async_debug(cond[`CA_DBG_ASYNC]), .async_mcheck(cond[`CA_MC_ASYNC]),
    .async_nmi(cond[`CA_NMI]), .ret_valid(ret_valid), .ret_level(ret_level),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(reg_rdata_q), .redirect_q(redirect_q), .redirect_addr_q(redirect_addr_q),
    .take_q(take_q), .take_pair_q(take_pair_q), .ms_q(ms_q), .irq_q(irq_q));

  // Same stimulus into a unit built without the debug level
  four_level_interrupt_unit #(
    .ENHANCED_DEBUG (0)
  ) u_dut_nodbg (
    .clk(clk), .nrst(nrst), .cur_addr(cur_addr), .sync_program(cond[`CA_PROGRAM]),
    .sync_debug(cond[`CA_DBG_SYNC]), .sync_err_report(cond[`CA_ERR_REPORT]),
    .async_ext_in(cond[`CA_EXT_IN]), .async_timer(cond[`CA_TIMER]),
    .async_doorbell(cond[`CA_DOORBELL]), .async_crit_in(cond[`CA_CRIT_IN]),
    .async_watchdog(cond[`CA_WATCHDOG]), .async_crit_db(cond[`CA_CRIT_DOORBELL]),
    .async_debug(cond[`CA_DBG_ASYNC]), .async_mcheck(cond[`CA_MC_ASYNC]),
    .async_nmi(cond[`CA_NMI]), .ret_valid(ret_valid), .ret_level(ret_level),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata_q(), .redirect_q(), .redirect_addr_q(),
    .take_q(take_b), .take_pair_q(pair_b), .ms_q(ms_b), .irq_q());

  pipe_model u_pipe (
    .clk(clk), .nrst(nrst), .fire(fire), .fire_mask(fire_mask), .fire_addr(fire_addr),
    .take_q(take_q), .redirect_q(redirect_q), .redirect_addr_q(redirect_addr_q),
    .cond_q(cond), .cur_addr_q(cur_addr));

  // Clock, 5 ns period
  initial begin
    forever #2.5 clk = ~clk;
  end

  // Hang guard, far above the 130 or so cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      complete_run;
    end
  end

  // ****************************************
  // Bus and event tasks
  // ****************************************
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input [7:0] a, input [31:0] e);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 `CHK("read data", e, reg_rdata_q)
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    #1 `CHK("irq", e, irq_q)
  endtask

  // Raise conditions, wait for the take, check target, pair and state
  task automatic take(input [11:0] m, input [3:0] c, input [2:0] p, input [4:0] s);
    int i;
    @(posedge clk);
    fire <= 1'b1;
    fire_mask <= m;
    fire_addr <= 32'h00004000;
    @(posedge clk);
    fire <= 1'b0;
    #1;
    for (i = 0; i < 10 && take_q !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("take", 1'b1, take_q)
    `CHK("vector", base | (32'(c) << `VEC_SHIFT), redirect_addr_q)
    `CHK("pair", p, take_pair_q)
    `CHK("state", s, ms_q)
  endtask

  // Expected pair and entry state from state 0x0F, by cause
  function automatic [2:0] pair_of(input int c);
    return (c < 3) ? `LVL_MC : (c < 5) ? `LVL_DBG : (c < 8) ? `LVL_CRIT : `LVL_STD;
  endfunction
  function automatic [4:0] ms_of(input int c);
    return (c < 3) ? 5'h00 : (c < 5) ? 5'h08 : (c < 8) ? 5'h0C : 5'h0E;
  endfunction

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    rd(`OFS_MACHINE_STATE, 32'h00000000);
    rd(`OFS_VECTOR_BASE, `VECTOR_BASE_RESET);
    rd(8'h40, 32'h00000000);
    wr(`OFS_VECTOR_BASE, base);
    wr(`OFS_IRQ_MASK, 32'h0000001F);
    wr(`OFS_MACHINE_STATE, 32'h0000000F);
    take(12'h001 << `CA_EXT_IN, `CA_EXT_IN, `LVL_STD, 5'h0E);
    rd(`OFS_SAVE_BASE, 32'h00004000);
    rd(`OFS_SAVE_BASE + 8'h04, 32'h0000000F);
    rd(`OFS_SYNDROME, 32'h00000200);
    rd(`OFS_IRQ_STATUS, 32'h00000001);
    irq_is(1'b1);
    wr(`OFS_IRQ_MASK, 32'h00000000);
    irq_is(1'b0);
    wr(`OFS_IRQ_MASK, 32'h0000001F);
    irq_is(1'b1);
    wr(`OFS_IRQ_STATUS, 32'h0000001F);
    irq_is(1'b0);
    // Return from the standard pair
    @(posedge clk);
    ret_valid <= 1'b1;
    ret_level <= `LVL_STD;
    @(posedge clk);
    ret_valid <= 1'b0;
    #1 `CHK("return flag", 1'b1, redirect_q)
    `CHK("return address", 32'h00004000, redirect_addr_q)
    `CHK("return state", 5'h0F, ms_q)
    // Every cause alone, each through its own level
    for (int i = 0; i < `NUM_CAUSES; i++) begin
      wr(`OFS_MACHINE_STATE, 32'h0000000F);
      take(12'h001 << i, i[3:0], pair_of(i), ms_of(i));
      // Without the debug level both debug causes enter at the critical level
      if (i == `CA_DBG_SYNC || i == `CA_DBG_ASYNC) begin
        `CHK("take without debug level", 1'b1, take_b)
        `CHK("pair without debug level", `LVL_CRIT, pair_b)
        `CHK("state without debug level", 5'h0C, ms_b)
      end
    end
    wr(`OFS_MACHINE_STATE, 32'h0000000F);
    take(12'hFFF, `CA_NMI, `LVL_MC, 5'h00);
    wr(`OFS_MACHINE_STATE, 32'h00000000);
    take((12'h001 << `CA_PROGRAM) | (12'h001 << `CA_EXT_IN), `CA_PROGRAM, `LVL_STD, 5'h00);
    wr(`OFS_MACHINE_STATE, 32'h00000000);
    take(12'h001 << `CA_NMI, `CA_NMI, `LVL_MC, 5'h00);
    wr(`OFS_MACHINE_STATE, 32'h0000001F);
    take(12'h001 << `CA_EXT_IN, `CA_EXT_IN, `LVL_GUEST, 5'h1E);
    rd(`OFS_SAVE_BASE + 8'h24, 32'h0000001F);
    complete_run;
  end
endmodule // tb_top
